// ===== logic/epo_top.sv
// file: energy pulse generator and comparator groups driving five outputs
// assumes energy increments arrive synchronous to mclk; software holds config
`timescale 1ns/1ps
// What this block does
// - two group-one and three group-two outputs, function selectable
// - outputs one and two readable as 0 off, 1 on at 0x260, 0x261
// - display state snapshot refreshes once per second only
// - in pulse mode emit one pulse per configured energy amount
// - one pulse length setting shared by both pulse outputs
// - pulse length limited to 10 ms through 10 s
// - gap between pulses at least pulse length and at least 10 ms
// - pulse rate follows measured power, spacing may be very long
// - pulse value gives energy per pulse
// - positive value pulses on positive energy only, negative likewise
// - active energy pulses only while drawing energy
// - reactive energy pulses with inductive or capacitive load, following the value's sign
// - five comparator groups of ten comparators each
// - group results combined by AND or OR, routed to an output
// - blink backlight when group enabled and group output active
// - running time counts while condition holds past lead time
// - comparator result changes after lead time of violation
// - result held for minimum on time, cleared after violation ends
module epo_top
  import epo_pkg::*;
#(
  parameter int EW = 32,
  parameter int TW = 16,
  parameter int PEND_W = 8,
  parameter int RUN_W = 32,
  parameter int MS_DIV = epo_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // energy increments per pulse channel, signed
  input wire logic [epo_pkg::NUM_PULSE-1:0] energy_valid,
  input wire logic signed [EW-1:0] energy_delta [epo_pkg::NUM_PULSE],
  // channel measures active (1) or reactive (0) energy
  input wire logic [epo_pkg::NUM_PULSE-1:0] energy_is_active,
  // pulse configuration
  input wire logic [TW-1:0] pulse_len_ms,
  input wire logic signed [EW-1:0] pulse_value [epo_pkg::NUM_PULSE],
  // comparator violations and settings, group major
  input wire logic [epo_pkg::NUM_GROUPS*epo_pkg::NUM_CMP-1:0] cmp_violation,
  input wire logic [epo_pkg::NUM_GROUPS*epo_pkg::NUM_CMP-1:0] cmp_enable,
  input wire logic [TW-1:0] cmp_lead_ms [epo_pkg::NUM_GROUPS],
  input wire logic [TW-1:0] cmp_min_on_ms [epo_pkg::NUM_GROUPS],
  input wire logic [epo_pkg::NUM_GROUPS-1:0] group_or,
  input wire logic [epo_pkg::NUM_GROUPS-1:0] group_blink,
  input wire logic [epo_pkg::OUT_SEL_W-1:0] group_out_sel [epo_pkg::NUM_GROUPS],
  // per output function
  input wire epo_pkg::epo_fn_type out_fn [epo_pkg::NUM_OUT],
  // status register read port
  input wire logic [11:0] stat_addr,
  output logic [15:0] stat_rdata,
  // outputs
  output logic [epo_pkg::NUM_OUT-1:0] switch_out,
  output logic [1:0] display_state,
  output logic backlight_max,
  output logic [RUN_W-1:0] run_time_ms [epo_pkg::NUM_GROUPS]
);
  import epo_pkg::*;

  localparam int DIV_W = $clog2(MS_DIV + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_DIV - 1);
  localparam logic [TW-1:0] LEN_MIN = TW'(PULSE_MIN_MS);
  localparam logic [TW-1:0] LEN_MAX = TW'(PULSE_MAX_MS);
  localparam logic [9:0] SEC_LAST = 10'(SEC_MS - 1);
  localparam logic [9:0] HALF_LAST = 10'(SEC_MS / 2 - 1);

  // millisecond time base
  logic [DIV_W-1:0] div_reg;
  logic ms_tick_reg;
  always_ff @(posedge mclk) begin
    if (rst) begin
      div_reg <= '0;
      ms_tick_reg <= 1'b0;
    end else begin
      ms_tick_reg <= div_reg == DIV_LAST;
      div_reg <= (div_reg == DIV_LAST) ? '0 : div_reg + 1'b1;
    end
  end

  wire [TW-1:0] len_clamp = (pulse_len_ms < LEN_MIN) ? LEN_MIN :
                            (pulse_len_ms > LEN_MAX) ? LEN_MAX : pulse_len_ms;
  // gap never below length nor 10 ms
  // one extra tick makes the gap one full millisecond longer than the clamped pulse length
  wire [TW-1:0] gap_ms = len_clamp + TW'(1);

  logic [NUM_PULSE-1:0] pulse_level;

  genvar p;
  generate
    for (p = 0; p < NUM_PULSE; p++) begin : g_pulse
      typedef enum {PS_IDLE, PS_HIGH, PS_GAP} epo_ps_type;
      epo_ps_type st_reg;
      logic signed [EW+1:0] acc_reg;
      logic [PEND_W-1:0] pend_reg;
      logic [TW-1:0] t_reg;
      wire pos_val = !pulse_value[p][EW-1];
      wire signed [EW+1:0] val_x = (EW+2)'(pulse_value[p]);
      wire signed [EW+1:0] mag = pos_val ? val_x : -val_x;
      wire signed [EW+1:0] d_x = (EW+2)'(energy_delta[p]);
      // sign filter, backstop: an active
      // channel never takes fed-back energy; reactive follows the sign
      wire sign_ok = pos_val ? (energy_delta[p] > 0) :
                     (energy_delta[p] < 0 && !energy_is_active[p]);
      wire signed [EW+1:0] d_abs = pos_val ? d_x : -d_x;
      wire take = energy_valid[p] && sign_ok && mag != 0;
      wire signed [EW+1:0] acc_in = take ? acc_reg + d_abs : acc_reg;
      // one pulse per value of energy
      wire due = mag != 0 && acc_in >= mag;
      wire pend_full = pend_reg == {PEND_W{1'b1}};
      wire start = st_reg == PS_IDLE && (pend_reg != 0 || due);
      always_ff @(posedge mclk) begin
        if (rst) begin
          acc_reg <= '0;
          pend_reg <= '0;
        end else begin
          acc_reg <= (due && !pend_full) ? acc_in - mag : acc_in;
          pend_reg <= pend_reg + PEND_W'(due && !pend_full) -
                      PEND_W'(start);
        end
      end
      always_ff @(posedge mclk) begin
        if (rst) begin
          st_reg <= PS_IDLE;
          t_reg <= '0;
        end else begin
          case (st_reg)
            PS_IDLE: begin
              t_reg <= '0;
              if (start) begin
                st_reg <= PS_HIGH;
              end
            end
            PS_HIGH: begin
              if (ms_tick_reg) begin
                t_reg <= t_reg + 1'b1;
              end
              if (ms_tick_reg && t_reg + 1'b1 >= len_clamp) begin
                st_reg <= PS_GAP;
                t_reg <= '0;
              end
            end
            PS_GAP: begin
              if (ms_tick_reg) begin
                t_reg <= t_reg + 1'b1;
              end
              if (ms_tick_reg && t_reg + 1'b1 >= gap_ms) begin
                st_reg <= PS_IDLE;
                t_reg <= '0;
              end
            end
            default: st_reg <= PS_IDLE;
          endcase
        end
      end
      assign pulse_level[p] = st_reg == PS_HIGH;
    end
  endgenerate

  logic [NUM_GROUPS*NUM_CMP-1:0] cmp_res;
  logic [NUM_GROUPS*NUM_CMP-1:0] cmp_cnt;
  logic [NUM_GROUPS-1:0] group_res;
  logic [NUM_GROUPS-1:0] group_cnt;
  logic [RUN_W-1:0] run_reg [NUM_GROUPS];

  genvar c;
  generate
    for (c = 0; c < NUM_GROUPS * NUM_CMP; c++) begin : g_cmp
      epo_comparator #(.TW(TW)) u_cmp (
        .mclk(mclk),
        .rst(rst),
        .ms_tick(ms_tick_reg),
        .enable(cmp_enable[c]),
        .lead_ms(cmp_lead_ms[c / NUM_CMP]),
        .min_on_ms(cmp_min_on_ms[c / NUM_CMP]),
        .violation(cmp_violation[c]),
        .result(cmp_res[c]),
        .counting(cmp_cnt[c])
      );
    end
  endgenerate

  genvar g;
  generate
    for (g = 0; g < NUM_GROUPS; g++) begin : g_grp
      wire [NUM_CMP-1:0] en = cmp_enable[g*NUM_CMP +: NUM_CMP];
      wire [NUM_CMP-1:0] r = cmp_res[g*NUM_CMP +: NUM_CMP];
      wire [NUM_CMP-1:0] k = cmp_cnt[g*NUM_CMP +: NUM_CMP];
      // and / or combination over enabled comparators
      assign group_res[g] = (en == '0) ? 1'b0 :
                            group_or[g] ? |(r & en) : &(r | ~en);
      assign group_cnt[g] = (en == '0) ? 1'b0 :
                            group_or[g] ? |(k & en) : &(k | ~en);
      always_ff @(posedge mclk) begin
        if (rst) begin
          run_reg[g] <= '0;
        end else if (ms_tick_reg && group_cnt[g]) begin
          run_reg[g] <= run_reg[g] + 1'b1;
        end
      end
    end
  endgenerate

  // output routing per function
  logic [NUM_OUT-1:0] out_next;
  always_comb begin
    out_next = '0;
    for (int o = 0; o < NUM_OUT; o++) begin
      case (out_fn[o])
        EPO_FN_PULSE: out_next[o] = (o < NUM_PULSE) ? pulse_level[o % 2]
                                                     : 1'b0;
        EPO_FN_CMP: begin
          for (int q = 0; q < NUM_GROUPS; q++) begin
            if (int'(group_out_sel[q]) == o && group_res[q]) begin
              out_next[o] = 1'b1;
            end
          end
        end
        default: out_next[o] = 1'b0;
      endcase
    end
  end

  logic [NUM_OUT-1:0] out_reg;
  always_ff @(posedge mclk) begin
    if (rst) begin
      out_reg <= '0;
    end else begin
      out_reg <= out_next;
    end
  end

  logic [9:0] sec_reg;
  logic [1:0] disp_reg;
  always_ff @(posedge mclk) begin
    if (rst) begin
      sec_reg <= '0;
      disp_reg <= '0;
    end else if (ms_tick_reg) begin
      sec_reg <= (sec_reg == SEC_LAST) ? '0 : sec_reg + 1'b1;
      if (sec_reg == SEC_LAST) begin
        disp_reg <= out_reg[1:0];
      end
    end
  end

  // blink at half-second rate while a blinking group is active
  wire blink_on = |(group_res & group_blink);
  wire half_edge = ms_tick_reg && (sec_reg == SEC_LAST || sec_reg == HALF_LAST);
  logic bl_reg;
  always_ff @(posedge mclk) begin
    if (rst) begin
      bl_reg <= 1'b1;
    end else if (!blink_on) begin
      bl_reg <= 1'b1;
    end else if (half_edge) begin
      bl_reg <= !bl_reg;
    end
  end

  // state words at 0x260 / 0x261
  wire [15:0] rd_next =
    (stat_addr == OUT1_STATE_ADDR) ? {15'h0000, out_reg[0]} :
    (stat_addr == OUT2_STATE_ADDR) ? {15'h0000, out_reg[1]} :
    16'h0000;
  logic [15:0] rd_reg;
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_reg <= 16'h0000;
    end else begin
      rd_reg <= rd_next;
    end
  end

  assign switch_out = out_reg;
  assign display_state = disp_reg;
  assign backlight_max = bl_reg;
  assign stat_rdata = rd_reg;
  assign run_time_ms = run_reg;
endmodule : epo_top

// ===== logic/epo_pkg.sv
// package: constants for the energy pulse and limit output block
// assumes a 250 MHz mclk and a 1 ms time base derived inside the block
package epo_pkg;
  localparam int CLK_MHZ = 250;
  localparam int MS_US = 1000;
  // cycles of mclk per millisecond tick
  localparam int MS_CYCLES = CLK_MHZ * MS_US;
  localparam int PULSE_MIN_MS = 10;
  localparam int PULSE_MAX_MS = 10000;
  localparam int SEC_MS = 1000;
  localparam logic [15:0] PULSE_LEN_RST = 16'h001E;
  localparam logic [11:0] OUT1_STATE_ADDR = 12'h260;
  localparam logic [11:0] OUT2_STATE_ADDR = 12'h261;
  localparam int NUM_GROUPS = 5;
  localparam int NUM_CMP = 10;
  localparam int NUM_OUT = 5;
  localparam int NUM_PULSE = 2;
  localparam int OUT_SEL_W = 3;
  typedef enum logic {EPO_OP_AND, EPO_OP_OR} epo_op_type;
  typedef enum logic [1:0] {EPO_FN_OFF, EPO_FN_PULSE, EPO_FN_CMP} epo_fn_type;
endpackage : epo_pkg

// ===== logic/epo_comparator.sv
// file: one limit comparator with lead time and minimum switch-on time
// assumes a one-cycle millisecond tick from the parent
`timescale 1ns/1ps
module epo_comparator #(
  parameter int TW = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic ms_tick,
  // configuration
  input wire logic enable,
  input wire logic [TW-1:0] lead_ms,
  input wire logic [TW-1:0] min_on_ms,
  // violation of the set limit by the measured value
  input wire logic violation,
  // result and a flag for time past the lead time
  output logic result,
  output logic counting
);
  import epo_pkg::*;
  logic [TW-1:0] lead_cnt_reg;
  logic [TW-1:0] on_cnt_reg;
  logic result_reg;
  wire viol = enable && violation;
  wire lead_done = lead_cnt_reg >= lead_ms;
  wire min_done = on_cnt_reg >= min_on_ms;
  wire lead_sat = lead_cnt_reg == {TW{1'b1}};
  wire on_sat = on_cnt_reg == {TW{1'b1}};

  always_ff @(posedge mclk) begin
    if (rst) begin
      lead_cnt_reg <= '0;
    end else if (!viol) begin
      lead_cnt_reg <= '0;
    end else if (ms_tick && !lead_sat) begin
      lead_cnt_reg <= lead_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      result_reg <= 1'b0;
      on_cnt_reg <= '0;
    end else if (!result_reg) begin
      on_cnt_reg <= '0;
      if (viol && lead_done) begin
        result_reg <= 1'b1;
      end
    end else begin
      if (ms_tick && !on_sat) begin
        on_cnt_reg <= on_cnt_reg + 1'b1;
      end
      if (!viol && min_done) begin
        result_reg <= 1'b0;
      end
    end
  end

  assign result = result_reg;
  assign counting = result_reg && viol && lead_done;
endmodule : epo_comparator

// ===== bench/epo_chk_sva.sv
// checker: timing relations seen at the pulse and limit outputs
// assumes group 0 drives output 1 whenever output 1 is a comparator output
`timescale 1ns/1ps
module epo_chk
  import epo_pkg::*;
#(
  parameter int MS_DIV = 10
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // configuration
  input wire logic [15:0] pulse_len_ms,
  input wire logic [15:0] cmp_min_on_ms [epo_pkg::NUM_GROUPS],
  input wire logic [epo_pkg::NUM_GROUPS-1:0] group_blink,
  input wire logic [2:0] group_out_sel [epo_pkg::NUM_GROUPS],
  input wire epo_pkg::epo_fn_type out_fn [epo_pkg::NUM_OUT],
  input wire logic [11:0] stat_addr,
  // outputs
  input wire logic [15:0] stat_rdata,
  input wire logic [epo_pkg::NUM_OUT-1:0] switch_out,
  input wire logic [1:0] display_state,
  input wire logic backlight_max,
  input wire logic [31:0] run_time_ms [epo_pkg::NUM_GROUPS]
);
  import epo_pkg::*;
  logic [31:0] hi0_reg, lo0_reg, hi1_reg, ds_reg;
  logic [1:0] dsp_reg;
  // cycles high, cycles low, cycles since the display snapshot moved
  always_ff @(posedge mclk) begin
    if (rst) begin
      hi0_reg <= 32'h0;
      lo0_reg <= 32'hFFFFFFFF;
      hi1_reg <= 32'h0;
      ds_reg <= 32'h0;
    end else begin
      hi0_reg <= switch_out[0] ? hi0_reg + 1 : 32'h0;
      lo0_reg <= switch_out[0] ? 32'h0 : lo0_reg + (lo0_reg != '1);
      hi1_reg <= switch_out[1] ? hi1_reg + 1 : 32'h0;
      ds_reg <= (display_state != dsp_reg) ? 32'h0 : ds_reg + 1;
    end
    dsp_reg <= display_state;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_pulse_width: assert property (
    $fell(switch_out[0]) && out_fn[0] == EPO_FN_PULSE |->
    hi0_reg >= (pulse_len_ms - 1) * MS_DIV &&
    hi0_reg <= pulse_len_ms * MS_DIV + 2) else $error("pulse width off");
  a_pulse_gap: assert property (
    $rose(switch_out[0]) && out_fn[0] == EPO_FN_PULSE |->
    lo0_reg >= pulse_len_ms * MS_DIV) else $error("pulse gap short");
  a_state_read: assert property (
    stat_addr == OUT1_STATE_ADDR |=>
    stat_rdata == {15'h0000, $past(switch_out[0])})
    else $error("state read wrong");
  a_display_rate: assert property (
    !$stable(display_state) |-> ds_reg >= (SEC_MS - 1) * MS_DIV)
    else $error("display refresh too fast");
  a_off_quiet: assert property (
    out_fn[3] == EPO_FN_OFF && $past(out_fn[3]) == EPO_FN_OFF |->
    !switch_out[3]) else $error("unused output drives");
  a_blink_idle: assert property (
    group_blink == 5'h00 && $past(group_blink) == 5'h00 |-> backlight_max)
    else $error("backlight dim without blink");
  a_run_step: assert property (
    1'b1 |=> run_time_ms[0] == $past(run_time_ms[0]) ||
    run_time_ms[0] == $past(run_time_ms[0]) + 1)
    else $error("run time jumped");
  a_min_on: assert property (
    $fell(switch_out[1]) && out_fn[1] == EPO_FN_CMP &&
    group_out_sel[0] == 3'h1 |->
    hi1_reg >= (cmp_min_on_ms[0] - 1) * MS_DIV)
    else $error("comparator on time short");
  c_pulse: cover property ($rose(switch_out[0]));
  c_cmp: cover property ($rose(switch_out[1]) && out_fn[1] == EPO_FN_CMP);
  c_dim: cover property ($fell(backlight_max));
endmodule : epo_chk
bind epo_top epo_chk #(.MS_DIV(MS_DIV)) u_chk (.mclk(mclk), .rst(rst),
  .pulse_len_ms(pulse_len_ms), .cmp_min_on_ms(cmp_min_on_ms),
  .group_blink(group_blink), .group_out_sel(group_out_sel),
  .out_fn(out_fn), .stat_addr(stat_addr), .stat_rdata(stat_rdata),
  .switch_out(switch_out), .display_state(display_state),
  .backlight_max(backlight_max), .run_time_ms(run_time_ms));

// ===== bench/epo_rx.sv
// model: pulse receiver on one switching output, counts pulses
// assumes the output is sampled on mclk
`timescale 1ns/1ps
module epo_rx (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // pin and count
  input wire logic pin,
  output logic [15:0] n_pulse
);
  logic pin_reg;
  always_ff @(posedge mclk) begin
    pin_reg <= pin;
    if (rst) n_pulse <= 16'h0000;
    else if (pin && !pin_reg) n_pulse <= n_pulse + 16'h0001;
  end
endmodule : epo_rx

// ===== bench/tb_epo_top.sv
// bench: pulse outputs into receiver models, comparator groups, status
// assumes a 1 ms tick of ten mclk cycles
`timescale 1ns/1ps
module tb_epo_top;
  import epo_pkg::*;
  logic mclk, rst, backlight_max;
  logic [1:0] energy_valid, energy_is_active, display_state;
  logic signed [31:0] energy_delta [2], pulse_value [2];
  logic [15:0] pulse_len_ms, stat_rdata, n_rx0, n_rx1, v;
  logic [49:0] cmp_violation, cmp_enable;
  logic [15:0] cmp_lead_ms [5], cmp_min_on_ms [5];
  logic [4:0] group_or, group_blink, switch_out;
  logic [2:0] group_out_sel [5];
  epo_fn_type out_fn [5];
  logic [11:0] stat_addr;
  logic [31:0] run_time_ms [5];
  logic dim;
  int errors, n_checks, k;
  epo_top #(.MS_DIV(10)) u_dut (.mclk(mclk), .rst(rst),
    .energy_valid(energy_valid), .energy_delta(energy_delta),
    .energy_is_active(energy_is_active), .pulse_len_ms(pulse_len_ms),
    .pulse_value(pulse_value), .cmp_violation(cmp_violation),
    .cmp_enable(cmp_enable), .cmp_lead_ms(cmp_lead_ms),
    .cmp_min_on_ms(cmp_min_on_ms), .group_or(group_or),
    .group_blink(group_blink), .group_out_sel(group_out_sel),
    .out_fn(out_fn), .stat_addr(stat_addr), .stat_rdata(stat_rdata),
    .switch_out(switch_out), .display_state(display_state),
    .backlight_max(backlight_max), .run_time_ms(run_time_ms));
  epo_rx u_rx0 (.mclk(mclk), .rst(rst), .pin(switch_out[0]), .n_pulse(n_rx0));
  epo_rx u_rx1 (.mclk(mclk), .rst(rst), .pin(switch_out[1]), .n_pulse(n_rx1));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task complete_run();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  task see(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : see
  task rd(input logic [11:0] a);
    @(posedge mclk);
    stat_addr <= a;
    see(1);
    v = stat_rdata;
  endtask : rd
  task strobe(input int ch, input logic signed [31:0] d);
    @(posedge mclk);
    energy_delta[ch] <= d;
    energy_valid[ch] <= 1'b1;
    @(posedge mclk);
    energy_valid[ch] <= 1'b0;
  endtask : strobe
  task wait_rx(input logic [15:0] e0, input logic [15:0] e1);
    for (k = 0; k < 3000 && !(n_rx0 === e0 && n_rx1 === e1); k++) see(1);
    chk({n_rx0, n_rx1}, {e0, e1});
    if (k == 3000) complete_run();
  endtask : wait_rx
  initial begin
    rst = 1'b1;
    energy_valid = 2'h0;
    energy_is_active = 2'h1;
    pulse_len_ms = 16'h001E;
    cmp_violation = '0;
    cmp_enable = '0;
    group_or = 5'h00;
    group_blink = 5'h00;
    stat_addr = 12'h000;
    foreach (energy_delta[i]) energy_delta[i] = 32'h0;
    pulse_value[0] = 32'h0000000A;
    pulse_value[1] = -32'sh0000000A;
    for (int i = 0; i < 5; i++) begin
      out_fn[i] = (i < 2) ? EPO_FN_PULSE : EPO_FN_OFF;
      cmp_lead_ms[i] = 16'h0005;
      cmp_min_on_ms[i] = 16'h0014;
      group_out_sel[i] = 3'h4;
    end
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    see(1);
    chk({switch_out, backlight_max}, 32'h1);
    rd(OUT1_STATE_ADDR);
    chk(v, 32'h0);
    strobe(0, 32'h00000019);
    strobe(0, 32'h00000009);
    see(20);
    rd(OUT1_STATE_ADDR);
    chk(v, 32'h1);
    wait_rx(16'h0003, 16'h0000);
    strobe(0, 32'h00000006);
    wait_rx(16'h0004, 16'h0000);
    strobe(0, -32'sh00000014);
    strobe(1, 32'h00000014);
    see(700);
    wait_rx(16'h0004, 16'h0000);
    strobe(1, -32'sh00000014);
    wait_rx(16'h0004, 16'h0002);
    @(posedge mclk);
    pulse_value[0] <= -32'sh0000000A;
    pulse_value[1] <= 32'h0000000A;
    strobe(0, -32'sh00000014);
    strobe(1, -32'sh00000014);
    see(700);
    wait_rx(16'h0004, 16'h0002);
    strobe(1, 32'h00000014);
    wait_rx(16'h0004, 16'h0004);
    see(700);
    @(posedge mclk);
    out_fn[1] <= EPO_FN_CMP;
    out_fn[2] <= EPO_FN_CMP;
    group_out_sel[0] <= 3'h1;
    group_out_sel[1] <= 3'h2;
    group_or <= 5'h01;
    cmp_enable <= 50'h0000000000C01;
    cmp_violation <= 50'h0000000000401;
    see(30);
    chk({switch_out[2], switch_out[1]}, 32'h0);
    see(40);
    chk({switch_out[2], switch_out[1]}, 32'h1);
    cmp_violation[0] <= 1'b0;
    see(100);
    chk(switch_out[1], 32'h1);
    see(150);
    chk(switch_out[1], 32'h0);
    cmp_violation <= 50'h0000000000C01;
    group_blink <= 5'h01;
    see(100);
    chk(switch_out[2], 32'h1);
    rd(OUT2_STATE_ADDR);
    chk(v, 32'h1);
    chk(switch_out[4:3], 32'h0);
    dim = 1'b0;
    for (k = 0; k < 11500; k++) begin
      see(1);
      if (backlight_max === 1'b0) dim = 1'b1;
    end
    chk(dim, 32'h1);
    chk(display_state, 32'h2);
    chk(run_time_ms[0] > 32'd1100 && run_time_ms[0] < 32'd1200, 1);
    chk(run_time_ms[0] - run_time_ms[1], 32'h2);
    chk(run_time_ms[2], 32'h0);
    complete_run();
  end
endmodule : tb_epo_top
